// file: src/rss_consts.svh
// constants for the reset source sequencer
`ifndef RSS_CONSTS_SVH
`define RSS_CONSTS_SVH
`define RSS_ADDR_STATUS4 12'h034
`define RSS_ADDR_STATUS2 12'h038
`define RSS_ADDR_CONFIG 12'h03C
`define RSS_BIT_POWER 0
`define RSS_BIT_PIN 1
`define RSS_BIT_LOWSUP 2
`define RSS_BIT_WDOG 3
`define RSS_FLAGS_W 4
`define RSS_CLK_MHZ 50
`define RSS_PIN_MIN_NS 50
`define RSS_PIN_CYC ((`RSS_PIN_MIN_NS * `RSS_CLK_MHZ + 999) / 1000)
`define RSS_DROP_HI_US 7
`define RSS_DROP_LO_US 24
`define RSS_DROP_HI_CYC (`RSS_DROP_HI_US * `RSS_CLK_MHZ)
`define RSS_DROP_LO_CYC (`RSS_DROP_LO_US * `RSS_CLK_MHZ)
`define RSS_CNT_W 24
`define RSS_CLOCK_SELECT_FUSES_RESET 4'h2
`endif

// file: src/rss_pkg.sv
// types for the reset source sequencer
package rss_pkg;
  typedef enum logic [1:0] {RSS_IDLE, RSS_HOLD, RSS_COUNT} rss_state_type;
  typedef struct packed {
    logic power_low;
    logic pin_low;
    logic supply_low;
    logic wdog;
  } rss_src_type;
endpackage

// file: src/rss_top.sv
// reset generation, start-up delay and reset cause recording
`include "rss_consts.svh"
// Behaviour
// R1: reset held while power detector reports supply below detection level
// R2: after power detector releases, reset held for fuse-selected delay
// R3: supply falling low again reasserts reset at once
// R4: pin low longer than 50 ns resets device; shorter pulses filtered
// R5: pin returning high starts delay; reset released when it expires
// R6: outside party may hold pin low to stretch power-on reset
// R7: supply-drop reset immediate when enabled by fuse, ignored otherwise
// R8: supply-drop release uses the same fuse-selected delay
// R9: level fuse selects 1.8V unprogrammed or 2.7V programmed threshold
// R10: drops shorter than 7 us at 2.7V or 24 us at 1.8V ignored
// R11: watchdog time-out gives a reset pulse of exactly one clock
// R12: trailing edge of watchdog pulse starts the start-up delay
// R13: two-flag view: pin flag bit 1, unchanged by watchdog, bits 7..2 zero
// R14: two-flag view: power flag bit 0 set by power-on only
// R15: software decodes two-flag view: none watchdog, bit1 pin, bit0 power
// R16: four-flag view: flags in bits 3..0, bits 7..4 read zero
// R17: watchdog flag bit 3 set by watchdog, cleared by power-on or write zero
// R18: supply-drop flag bit 2 set by drop, cleared by power-on or write zero
// R19: pin flag bit 1 set by pin reset, cleared by power-on or write zero
// R20: power flag bit 0 set by power-on, cleared only by writing zero
// R21: software should read then clear the status early after start-up
// R22: sleep wake-up uses only the clock-count part of the delay
// R23: all enabled sources ORed into one reset; all active sources flagged
module rss_top #(
  parameter int unsigned RT_SHORT = 1024,
  parameter int unsigned RT_LONG = 16384,
  parameter int unsigned RT_SHORT_LO = 256,
  parameter int unsigned RT_LONG_LO = 4096,
  parameter int unsigned DROP_HI_CYC = `RSS_DROP_HI_CYC,
  parameter int unsigned DROP_LO_CYC = `RSS_DROP_LO_CYC
) (
  // clock and supply-level reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // detector, pin, watchdog, oscillator tick and wake inputs
  input wire logic power_low_i,
  input wire logic reset_pin_n_i,
  input wire logic supply_drop_detect_i,
  input wire logic watchdog_timeout_i,
  input wire logic wdog_osc_tick_i,
  input wire logic sleep_wake_i,
  // fuses
  input wire logic supply_drop_enable_fuse_i,
  input wire logic supply_drop_level_fuse_i,
  input wire logic [3:0] clock_select_fuses_i,
  // ahb-lite slave
  input wire logic hsel_i,
  input wire logic [11:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // reset and drop-level outputs
  output logic core_reset_o,
  output logic drop_level_high_o
);
  // synchronisers for asynchronous inputs
  logic [1:0] pwr_s_reg, pin_s_reg, drop_s_reg, wdt_s_reg, tick_s_reg, wake_s_reg;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pwr_s_reg <= 2'h3;
      pin_s_reg <= 2'h0;
      drop_s_reg <= 2'h0;
      wdt_s_reg <= 2'h0;
      tick_s_reg <= 2'h0;
      wake_s_reg <= 2'h0;
    end else begin
      pwr_s_reg <= {pwr_s_reg[0], power_low_i};
      pin_s_reg <= {pin_s_reg[0], ~reset_pin_n_i};
      drop_s_reg <= {drop_s_reg[0], supply_drop_detect_i};
      wdt_s_reg <= {wdt_s_reg[0], watchdog_timeout_i};
      tick_s_reg <= {tick_s_reg[0], wdog_osc_tick_i};
      wake_s_reg <= {wake_s_reg[0], sleep_wake_i};
    end
  end

  // power detector acts at once, bypassing the synchroniser
  wire power_low = power_low_i | pwr_s_reg[1]; // R1 R3

  // pin filter: must be low for the minimum width in clock cycles
  localparam int unsigned PIN_CYC = `RSS_PIN_CYC;
  logic [3:0] pin_cnt_reg;
  logic pin_low_reg;
  wire pin_raw = pin_s_reg[1];
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_cnt_reg <= 4'h0;
      pin_low_reg <= 1'b0;
    end else if (!pin_raw) begin
      pin_cnt_reg <= 4'h0;
      pin_low_reg <= 1'b0;
    end else if (pin_cnt_reg < 4'(PIN_CYC - 1)) begin
      pin_cnt_reg <= pin_cnt_reg + 4'h1;
    end else begin
      pin_low_reg <= 1'b1; // R4 R6
    end
  end

  // supply-drop persistence filter
  logic [15:0] drop_cnt_reg;
  logic drop_low_reg;
  wire [15:0] drop_limit = supply_drop_level_fuse_i ? 16'(DROP_HI_CYC) : 16'(DROP_LO_CYC); // R10
  wire drop_raw = drop_s_reg[1] & supply_drop_enable_fuse_i; // R7
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      drop_cnt_reg <= 16'h0;
      drop_low_reg <= 1'b0;
    end else if (!drop_raw) begin
      drop_cnt_reg <= 16'h0;
      drop_low_reg <= 1'b0;
    end else if (drop_cnt_reg < drop_limit - 16'h1) begin
      drop_cnt_reg <= drop_cnt_reg + 16'h1;
    end else begin
      drop_low_reg <= 1'b1; // R7 R10
    end
  end

  // watchdog: one-clock pulse on rising edge of the request
  logic wdt_prev_reg;
  wire wdt_pulse = wdt_s_reg[1] & ~wdt_prev_reg; // R11
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) wdt_prev_reg <= 1'b0;
    else wdt_prev_reg <= wdt_s_reg[1];
  end

  wire src_any = power_low | pin_low_reg | drop_low_reg | wdt_pulse; // R23

  // delay selection: real-time part in watchdog ticks, clock part in cycles
  function automatic logic [`RSS_CNT_W-1:0] clk_part(input logic [3:0] sel);
    case (sel)
      4'hF, 4'hE, 4'hD, 4'h9: clk_part = `RSS_CNT_W'(1024);
      4'hC, 4'hB, 4'hA: clk_part = `RSS_CNT_W'(16384);
      4'h8: clk_part = `RSS_CNT_W'(32768);
      default: clk_part = `RSS_CNT_W'(6);
    endcase
  endfunction
  function automatic logic [1:0] rt_kind(input logic [3:0] sel);
    case (sel)
      4'hE, 4'hB, 4'h6, 4'h3, 4'h0: rt_kind = 2'h1;
      4'hD, 4'hA, 4'h9, 4'h8, 4'h5, 4'h2: rt_kind = 2'h2;
      default: rt_kind = 2'h0;
    endcase
  endfunction
  wire [1:0] kind = rt_kind(clock_select_fuses_i);
  wire lvl = supply_drop_level_fuse_i; // R9
  wire [`RSS_CNT_W-1:0] rt_ticks = (kind == 2'h1) ? `RSS_CNT_W'(lvl ? RT_SHORT : RT_SHORT_LO) :
                                  (kind == 2'h2) ? `RSS_CNT_W'(lvl ? RT_LONG : RT_LONG_LO) :
                                  `RSS_CNT_W'(0);
  wire [`RSS_CNT_W-1:0] ck_cycles = clk_part(clock_select_fuses_i);

  // sequencer
  rss_pkg::rss_state_type state_reg, state_next;
  logic [`RSS_CNT_W-1:0] rt_cnt_reg, ck_cnt_reg;
  logic core_rst_reg;
  logic tick_prev_reg;
  wire tick = tick_s_reg[1] & ~tick_prev_reg;
  logic wake_prev_reg;
  wire wake = wake_s_reg[1] & ~wake_prev_reg;
  wire done = (rt_cnt_reg == `RSS_CNT_W'(0)) && (ck_cnt_reg <= `RSS_CNT_W'(1));
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      rss_pkg::RSS_IDLE: if (src_any) state_next = rss_pkg::RSS_HOLD;
      rss_pkg::RSS_HOLD: if (!src_any) state_next = rss_pkg::RSS_COUNT; // R2 R5 R8 R12
      rss_pkg::RSS_COUNT: begin
        if (src_any) state_next = rss_pkg::RSS_HOLD; // R3
        else if (done) state_next = rss_pkg::RSS_IDLE;
      end
      default: state_next = rss_pkg::RSS_HOLD;
    endcase
  end
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= rss_pkg::RSS_HOLD;
      rt_cnt_reg <= `RSS_CNT_W'(0);
      ck_cnt_reg <= `RSS_CNT_W'(0);
      tick_prev_reg <= 1'b0;
      wake_prev_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      tick_prev_reg <= tick_s_reg[1];
      wake_prev_reg <= wake_s_reg[1];
      if (state_reg != rss_pkg::RSS_COUNT) begin
        rt_cnt_reg <= rt_ticks;
        ck_cnt_reg <= ck_cycles;
      end else if (rt_cnt_reg != `RSS_CNT_W'(0)) begin
        if (tick) rt_cnt_reg <= rt_cnt_reg - `RSS_CNT_W'(1);
      end else if (ck_cnt_reg != `RSS_CNT_W'(0)) begin
        ck_cnt_reg <= ck_cnt_reg - `RSS_CNT_W'(1);
      end
    end
  end

  // wake-up stall: clock-count part only, no reset flags touched
  logic [`RSS_CNT_W-1:0] wake_cnt_reg;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) wake_cnt_reg <= `RSS_CNT_W'(0);
    else if (wake) wake_cnt_reg <= ck_cycles; // R22
    else if (wake_cnt_reg != `RSS_CNT_W'(0)) wake_cnt_reg <= wake_cnt_reg - `RSS_CNT_W'(1);
  end

  // output reset: combined source, hold and delay, wake stall
  wire core_rst_next = src_any || (state_next != rss_pkg::RSS_IDLE) ||
                       (wake_cnt_reg > `RSS_CNT_W'(1)); // R23
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) core_rst_reg <= 1'b1;
    else core_rst_reg <= core_rst_next;
  end

  // ahb-lite address phase capture
  logic wr_pend_reg;
  logic [11:0] addr_reg;
  wire take = hsel_i & htrans_i[1] & hready_i;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_pend_reg <= 1'b0;
      addr_reg <= 12'h000;
    end else begin
      wr_pend_reg <= take & hwrite_i;
      if (take) addr_reg <= haddr_i;
    end
  end
  wire wr4 = wr_pend_reg && addr_reg == `RSS_ADDR_STATUS4;
  wire wr2 = wr_pend_reg && addr_reg == `RSS_ADDR_STATUS2;

  // cause flags; a set in the same cycle wins over a software clear
  logic [`RSS_FLAGS_W-1:0] flags_reg, flags_next;
  logic [1:0] flags2_reg, flags2_next;
  wire por = power_low;
  always_comb begin
    flags_next = flags_reg;
    flags2_next = flags2_reg;
    if (wr4) flags_next = flags_reg & hwdata_i[`RSS_FLAGS_W-1:0]; // R17 R18 R19 R20
    if (wr2) flags2_next = flags2_reg & hwdata_i[1:0];
    if (por) begin
      flags_next = 4'h1; // R17 R18 R19 R20
      flags2_next[`RSS_BIT_POWER] = 1'b1; // R14
    end
    if (pin_low_reg) begin
      flags_next[`RSS_BIT_PIN] = 1'b1; // R19 R23
      flags2_next[`RSS_BIT_PIN] = 1'b1; // R13
    end
    if (drop_low_reg) flags_next[`RSS_BIT_LOWSUP] = 1'b1; // R18 R23
    if (wdt_pulse) flags_next[`RSS_BIT_WDOG] = 1'b1; // R17
  end
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      flags_reg <= 4'h1;
      flags2_reg <= 2'h1;
    end else begin
      flags_reg <= flags_next;
      flags2_reg <= flags2_next;
    end
  end

  // read data registered from the address phase
  wire [31:0] rd_sel = (haddr_i == `RSS_ADDR_STATUS4) ? {28'h0, flags_next} : // R16
                       (haddr_i == `RSS_ADDR_STATUS2) ? {30'h0, flags2_next} : // R13
                       (haddr_i == `RSS_ADDR_CONFIG) ?
                         {24'h0, 1'b0, 1'b0, supply_drop_enable_fuse_i, lvl, clock_select_fuses_i} :
                       32'h0;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) hrdata_o <= 32'h0;
    else if (take && !hwrite_i) hrdata_o <= rd_sel;
  end
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
      drop_level_high_o <= 1'b0;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
      drop_level_high_o <= lvl; // R9
    end
  end
  assign core_reset_o = core_rst_reg;
endmodule // rss_top

// file: sim/rss_top_sva.sv
// assertion checker for the reset source sequencer
module rss_top_sva #(
  parameter int unsigned DROP_LO_CYC = 1200
) (
  // clock, reset and sources
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic power_low_i,
  input wire logic reset_pin_n_i,
  input wire logic supply_drop_detect_i,
  input wire logic supply_drop_enable_fuse_i,
  input wire logic watchdog_timeout_i,
  // bus
  input wire logic hsel_i,
  input wire logic [11:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [31:0] hrdata_o,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  // result
  input wire logic core_reset_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  logic [15:0] drop_run;
  wire take_rd = hsel_i & htrans_i[1] & hreadyout_o & ~hwrite_i;
  // longest filter plus sync margin must have fired by the time this runs out
  always_ff @(posedge mclk_i or posedge rst_i)
    if (rst_i) drop_run <= 16'h0000;
    else if (supply_drop_detect_i & supply_drop_enable_fuse_i) drop_run <= drop_run + 16'h0001;
    else drop_run <= 16'h0000;
  a_power_holds: assert property (power_low_i |=> core_reset_o)
    else $error("reset not held while supply low");
  a_pin_resets: assert property (!reset_pin_n_i [*6] |-> ##[0:2] core_reset_o)
    else $error("long pin low gave no reset");
  a_drop_resets: assert property (drop_run == DROP_LO_CYC + 5 |-> core_reset_o)
    else $error("long enabled dip gave no reset");
  a_wdog_resets: assert property ($rose(watchdog_timeout_i) |-> ##[1:5] core_reset_o)
    else $error("watchdog gave no reset");
  a_release_quiet: assert property ($fell(core_reset_o) |->
    $past(reset_pin_n_i, 6) && !$past(power_low_i, 6))
    else $error("reset released too soon");
  a_four_high: assert property (take_rd && haddr_i == 12'h034 |=> hrdata_o[31:4] == 28'h0)
    else $error("four flag upper bits set");
  a_two_high: assert property (take_rd && haddr_i == 12'h038 |=> hrdata_o[31:2] == 30'h0)
    else $error("two flag upper bits set");
  a_rdata_holds: assert property (!take_rd |=> $stable(hrdata_o))
    else $error("read data moved without a read");
  a_ready_okay: assert property (hreadyout_o && !hresp_o)
    else $error("bus wait or error seen");
  c_pin: cover property (!reset_pin_n_i [*6]);
  c_wdog: cover property ($rose(watchdog_timeout_i));
  c_release: cover property ($fell(core_reset_o));
endmodule // rss_top_sva

// file: sim/rss_far_side.sv
// reset pin driver, supply detectors, watchdog and its oscillator
module rss_far_side (
  // clock
  input wire logic mclk_i,
  // levels
  output logic power_low_o,
  output logic reset_pin_n_o,
  output logic drop_o,
  output logic wdog_o,
  output logic tick_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] act = 4'h0;
  logic [1:0] div = 2'h0;
  assign power_low_o = act[0];
  assign reset_pin_n_o = ~act[1];
  assign drop_o = act[2];
  assign wdog_o = act[3];
  assign tick_o = div[1];
  always @(posedge mclk_i) div <= div + 2'h1;
  // the pin may be held low as long as wanted to stretch a reset
  task automatic pulse(input int sel, input int n);
    @(posedge mclk_i);
    act[sel] <= 1'h1;
    repeat (n) @(posedge mclk_i);
    act[sel] <= 1'h0;
  endtask
endmodule // rss_far_side

// file: sim/testbench.sv
// self-checking bench for the reset source sequencer
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_i = 1'h0;
  logic rst_i = 1'h1;
  logic en_f = 1'h1;
  logic lv_f = 1'h1;
  logic hsel = 1'h0;
  logic wake = 1'h0;
  logic [3:0] clock_select_fuses = 4'h2;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic ready, resp, rst_o, lv_o, pwr, pin_n, drop, wdog, tick;
  int err_total = 0;
  int samples_checked = 0;
  int cycles = 0;
  always #10 mclk_i = ~mclk_i;
  rss_far_side u_far (.mclk_i(mclk_i), .power_low_o(pwr), .reset_pin_n_o(pin_n),
    .drop_o(drop), .wdog_o(wdog), .tick_o(tick));
  rss_top #(.RT_SHORT(4), .RT_LONG(8), .RT_SHORT_LO(2), .RT_LONG_LO(3), .DROP_HI_CYC(5),
    .DROP_LO_CYC(9)) u_dut (.mclk_i(mclk_i), .rst_i(rst_i), .power_low_i(pwr),
    .reset_pin_n_i(pin_n), .supply_drop_detect_i(drop), .watchdog_timeout_i(wdog),
    .wdog_osc_tick_i(tick), .sleep_wake_i(wake), .supply_drop_enable_fuse_i(en_f),
    .supply_drop_level_fuse_i(lv_f), .clock_select_fuses_i(clock_select_fuses), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
    .hwdata_i(hwdata), .hready_i(ready), .hrdata_o(hrdata), .hreadyout_o(ready),
    .hresp_o(resp), .core_reset_o(rst_o), .drop_level_high_o(lv_o));
  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic complete_run;
    $display("mismatches %0d checks %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd,
      output logic [31:0] rd);
    @(posedge mclk_i);
    hsel <= 1'h1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge mclk_i);
    while (ready !== 1'h1) @(posedge mclk_i);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge mclk_i);
    while (ready !== 1'h1) @(posedge mclk_i);
    rd = hrdata;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] wd);
    logic [31:0] d;
    bus(1'h1, a, wd, d);
  endtask
  task automatic rc(input string n, input logic [11:0] a, input logic [31:0] m, e);
    logic [31:0] d;
    bus(1'h0, a, 32'h0, d);
    check(n, d & m, e);
  endtask
  task automatic rst_is(input string n, input logic e);
    check(n, {31'h0, rst_o}, {31'h0, e});
  endtask
  task automatic wait_rel;
    for (int i = 0; i < 400 && rst_o !== 1'h0; i++) @(posedge mclk_i);
    rst_is("release", 1'h0);
  endtask
  task automatic t_power_up;
    wait_rel;
    rc("four", 12'h034, 32'hFFFFFFFF, 32'h1);
    rc("two", 12'h038, 32'hFFFFFFFD, 32'h1);
    wr(12'h034, 32'h0);
    rc("clear", 12'h034, 32'hFFFFFFFF, 32'h0);
    wr(12'h040, 32'hFFFFFFFF);
    rc("unmapped", 12'h040, 32'hFFFFFFFF, 32'h0);
  endtask
  task automatic t_pin;
    u_far.pulse(1, 2);
    repeat (6) @(posedge mclk_i);
    rst_is("short pin", 1'h0);
    u_far.pulse(1, 8);
    rst_is("pin", 1'h1);
    wait_rel;
    rc("pin four", 12'h034, 32'hF, 32'h2);
    rc("pin two", 12'h038, 32'h2, 32'h2);
  endtask
  task automatic t_wdog;
    u_far.pulse(3, 3);
    repeat (3) @(posedge mclk_i);
    rst_is("wdog", 1'h1);
    wait_rel;
    rc("wd four", 12'h034, 32'hF, 32'hA);
    rc("wd two", 12'h038, 32'h2, 32'h2);
  endtask
  task automatic t_drop;
    u_far.pulse(2, 3);
    repeat (6) @(posedge mclk_i);
    rst_is("short dip", 1'h0);
    u_far.pulse(2, 16);
    rst_is("dip", 1'h1);
    wait_rel;
    rc("dip four", 12'h034, 32'hF, 32'hE);
    wr(12'h034, 32'hFFFFFFF7);
    rc("wd clear", 12'h034, 32'hF, 32'h6);
    lv_f <= 1'h0;
    repeat (3) @(posedge mclk_i);
    check("level", {31'h0, lv_o}, 32'h0);
    u_far.pulse(2, 7);
    repeat (6) @(posedge mclk_i);
    rst_is("low short", 1'h0);
    u_far.pulse(2, 16);
    rst_is("low dip", 1'h1);
    wait_rel;
    en_f <= 1'h0;
    u_far.pulse(2, 30);
    rst_is("dip off", 1'h0);
  endtask
  task automatic t_pwr;
    wr(12'h034, 32'h0);
    u_far.pulse(1, 8);
    wait_rel;
    u_far.pulse(0, 4);
    rst_is("power", 1'h1);
    wait_rel;
    rc("por", 12'h034, 32'hFF, 32'h1);
  endtask
  // wake from sleep stalls the core for the clock-count part only
  task automatic t_wake;
    @(posedge mclk_i);
    clock_select_fuses <= 4'h7;
    wake <= 1'h1;
    repeat (5) @(posedge mclk_i);
    rst_is("wake stall", 1'h1);
    wake <= 1'h0;
    wait_rel;
    rc("wake flags", 12'h034, 32'hF, 32'h1);
  endtask
  initial begin
    repeat (8) @(posedge mclk_i);
    rst_i <= 1'h0;
    t_power_up;
    t_pin;
    t_wdog;
    t_drop;
    t_pwr;
    t_wake;
    complete_run;
  end
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      complete_run;
    end
  end
endmodule // testbench
bind rss_top rss_top_sva #(.DROP_LO_CYC(DROP_LO_CYC)) u_sva (.mclk_i(mclk_i), .rst_i(rst_i),
  .power_low_i(power_low_i), .reset_pin_n_i(reset_pin_n_i), .hsel_i(hsel_i),
  .supply_drop_detect_i(supply_drop_detect_i), .watchdog_timeout_i(watchdog_timeout_i),
  .supply_drop_enable_fuse_i(supply_drop_enable_fuse_i), .haddr_i(haddr_i),
  .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hrdata_o(hrdata_o),
  .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .core_reset_o(core_reset_o));
